// ===== hw/acpisq_pkg.sv
// Constants, types and register map of the ACPI sleep power sequencer
package acpisq_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned DEGLITCH_US = 2;
	localparam int unsigned SLEEP_DELAY_US = 200;
	localparam int unsigned CFG_WINDOW_MS = 3;
	localparam int unsigned ACT_ASSESS_MS = 25;

	// Least times round up, and never below one cycle
	// Product kept 64 bits wide so millisecond counts fit
	function automatic int unsigned us_to_cyc(input int unsigned us);
		longint unsigned c;
		c = (64'(us) * 64'(CLK_HZ) + 64'd999_999) / 64'd1_000_000;
		return (c == 64'd0) ? 32'd1 : 32'(c);
	endfunction

	localparam int unsigned DEGLITCH_CYC = us_to_cyc(DEGLITCH_US);
	localparam int unsigned SLEEP_DELAY_CYC = us_to_cyc(SLEEP_DELAY_US);
	localparam int unsigned CFG_WINDOW_CYC = us_to_cyc(CFG_WINDOW_MS * 1000);
	localparam int unsigned ACT_ASSESS_CYC = us_to_cyc(ACT_ASSESS_MS * 1000);

	localparam int unsigned TMR_W = 20;
	localparam int unsigned FLT_W = 6;

	// ==========================================================
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FLOG = 8'h08;
	localparam int unsigned CTRL_SHDN_BIT = 0;
	localparam int unsigned FLOG_W = 6;
	localparam logic [1:0] REQ_RST = 2'h3;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		PH_OFF, PH_FAST, PH_RAMP1, PH_DIS1, PH_WAIT3, PH_RAMP2, PH_DIS2,
		PH_SLEEP, PH_MAINS, PH_ACTRAMP, PH_ACTDIS, PH_ACTIVE, PH_SHDN,
		PH_LATCHOFF
	} acpisq_phase_t;

	typedef enum logic [1:0] {AC_S0, AC_S3, AC_S5} acpisq_acpi_t;

	typedef struct packed {
		logic bias_por_ok;
		logic ss_ext_low;
		logic ss_ge_1v0;
		logic ss_ge_1v25;
		logic ss_ge_2v45;
		logic ss_ge_2v75;
		logic sb33_in_reg;
		logic main33_ok;
		logic main5_ok;
		logic main12_ok;
		logic memory_voltage_select_low;
		logic memory_voltage_select_high;
		logic uv_sb33;
		logic uv_mem33;
		logic uv_mem25;
		logic uv_clk;
		logic uv_dual5;
	} acpisq_sense_t;

	typedef struct packed {
		logic ss_fast_charge;
		logic ss_charge;
		logic ss_discharge;
		logic sb33_ref_ramp;
		logic dual5_output;
		logic dual5_standby_gate;
		logic active_switch_gate;
		logic clkchip_output;
		logic mem33_output;
		logic mem25_sleep;
		logic mem25_active;
		logic uv_arm_sb33;
		logic uv_arm_rest;
		logic fault;
	} acpisq_drive_t;

endpackage

// ===== hw/acpisq_top.sv
// ACPI sleep power sequencer with AHB-Lite status and control registers
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps

module acpisq_top
	import acpisq_pkg::*;
#(
	parameter int unsigned CFG_WINDOW_CYC_P = CFG_WINDOW_CYC,
	parameter int unsigned ACT_ASSESS_CYC_P = ACT_ASSESS_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// System sleep control
	input wire logic suspend_request_n_i,
	input wire logic softoff_request_n_i,
	input wire logic dual5_sleep_enable_i,
	// Analog comparators and supply monitors
	input wire acpisq_sense_t sense_i,
	// Power stage drive
	output acpisq_drive_t drive_o,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic [1:0] hresp_o
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic [1:0] req;
		logic [1:0][FLT_W-1:0] fcnt;
		acpisq_phase_t phase;
		acpisq_acpi_t acpi;
		logic [TMR_W-1:0] tmr;
		logic pend;
		logic boot_act;
		logic en_lat;
		logic m33;
		logic m25;
		logic arm_sb;
		logic arm_rest;
		logic forced;
		logic lock;
		logic shdn_sw;
		logic [FLOG_W-1:0] flog;
		acpisq_drive_t drv;
		logic ad_v;
		logic ad_w;
		logic [7:0] ad_a;
		logic [31:0] rdata;
		logic rdy;
		logic [1:0] resp;
	} acpisq_state_t;

	acpisq_state_t q;
	acpisq_state_t n;

	function automatic logic reg_is(input logic [7:0] a,
		input logic [7:0] off);
		return a == off;
	endfunction

	logic sus;
	logic soff;
	logic wake;
	logic mains;
	logic shdn;
	logic act;
	logic slp;
	logic up;
	logic f_sb;
	logic f_mem;
	logic f_d5;
	logic f_clk;
	logic loss_evt;
	logic lock_evt;
	logic take;
	logic wr_ph;
	logic [FLOG_W-1:0] clr;

	always_comb begin
		n = q;
		loss_evt = 1'b0;
		lock_evt = 1'b0;
		mains = sense_i.main33_ok & sense_i.main5_ok & sense_i.main12_ok;

		// ======================================================
		// Synchronisers and deglitch filters
		n.sy1 = {dual5_sleep_enable_i, softoff_request_n_i,
			suspend_request_n_i};
		n.sy2 = q.sy1;
		for (int i = 0; i < 2; i++) begin
			if (q.sy2[i] == q.req[i]) begin
				n.fcnt[i] = '0;
			end else if (q.fcnt[i] == FLT_W'(DEGLITCH_CYC - 1)) begin
				n.req[i] = q.sy2[i];
				n.fcnt[i] = '0;
			end else begin
				n.fcnt[i] = q.fcnt[i] + 1'b1;
			end
		end
		sus = q.req[0];
		soff = q.req[1];
		wake = sus & soff;

		// ======================================================
		// Register writes take effect at the end of the data phase
		wr_ph = q.ad_v & q.ad_w;
		clr = '0;
		if (wr_ph && reg_is(q.ad_a, REG_FLOG)) begin
			clr = hwdata_i[FLOG_W-1:0];
		end
		if (wr_ph && reg_is(q.ad_a, REG_CTRL)) begin
			n.shdn_sw = hwdata_i[CTRL_SHDN_BIT];
		end
		shdn = sense_i.ss_ext_low | q.shdn_sw;

		// ======================================================
		// Sequencer
		n.tmr = q.tmr + 1'b1;
		case (q.phase)
			PH_OFF: begin
				if (sense_i.bias_por_ok) begin
					n.phase = PH_FAST;
					n.boot_act = wake;
					n.acpi = AC_S0;
				end
			end
			PH_FAST: begin
				if (sense_i.ss_ge_1v0) begin
					n.phase = PH_RAMP1;
				end
			end
			PH_RAMP1: begin
				if (sense_i.sb33_in_reg && sense_i.ss_ge_2v75) begin
					n.arm_sb = 1'b1;
					n.phase = PH_DIS1;
				end
			end
			PH_DIS1: begin
				if (!sense_i.ss_ge_1v25) begin
					n.phase = PH_WAIT3;
					n.tmr = '0;
				end
			end
			PH_WAIT3: begin
				if (q.tmr == TMR_W'(CFG_WINDOW_CYC_P - 1)) begin
					n.m33 = !sense_i.memory_voltage_select_low;
					n.m25 = !sense_i.memory_voltage_select_high;
					n.en_lat = q.sy2[2];
					n.tmr = '0;
					if (q.boot_act) begin
						n.phase = PH_MAINS;
					end else begin
						n.phase = PH_RAMP2;
						n.acpi = soff ? AC_S3 : AC_S5;
					end
				end
			end
			PH_RAMP2: begin
				if (sense_i.ss_ge_2v75) begin
					n.arm_rest = 1'b1;
					n.phase = PH_DIS2;
				end
			end
			PH_DIS2: begin
				if (!sense_i.ss_ge_1v25) begin
					n.phase = PH_SLEEP;
				end
			end
			PH_SLEEP: begin
				if (mains) begin
					n.forced = 1'b0;
				end
				// Only a full wake leaves sleep; S3 and S5 never swap
				if (wake) begin
					n.phase = PH_MAINS;
					n.tmr = '0;
					if (q.acpi == AC_S5) begin
						n.m33 = !sense_i.memory_voltage_select_low;
						n.m25 = !sense_i.memory_voltage_select_high;
					end
				end
			end
			PH_MAINS: begin
				if (!sus) begin
					n.phase = (q.acpi == AC_S0) ? PH_RAMP2 : PH_SLEEP;
					if (q.acpi == AC_S0) begin
						n.acpi = soff ? AC_S3 : AC_S5;
					end
				end else if (!mains) begin
					n.tmr = '0;
				end else if (q.tmr == TMR_W'(ACT_ASSESS_CYC_P - 1)) begin
					n.phase = PH_ACTRAMP;
					n.acpi = AC_S0;
					n.pend = 1'b0;
				end
			end
			PH_ACTRAMP: begin
				if (sense_i.ss_ge_2v75) begin
					n.arm_rest = 1'b1;
					n.phase = PH_ACTDIS;
				end
			end
			PH_ACTDIS: begin
				if (!sense_i.ss_ge_2v45) begin
					n.phase = PH_ACTIVE;
				end
			end
			PH_ACTIVE: begin
				// Soft-off alone with suspend high is ignored
				if (!q.pend) begin
					if (!sus) begin
						n.pend = 1'b1;
						n.tmr = '0;
					end
				end else if (sus) begin
					n.pend = 1'b0;
				end else if (q.tmr == TMR_W'(SLEEP_DELAY_CYC - 1)) begin
					n.pend = 1'b0;
					n.acpi = soff ? AC_S3 : AC_S5;
					n.phase = PH_SLEEP;
				end
			end
			PH_SHDN: begin
				if (!shdn) begin
					n.phase = PH_FAST;
					n.boot_act = wake;
					n.acpi = AC_S0;
				end
			end
			PH_LATCHOFF: begin
				n.phase = PH_LATCHOFF;
			end
			default: begin
				n.phase = PH_OFF;
			end
		endcase

		// Mains loss while active drops to a forced soft-off
		if (q.phase inside {PH_ACTRAMP, PH_ACTDIS, PH_ACTIVE} && !mains) begin
			n.acpi = AC_S5;
			n.phase = PH_SLEEP;
			n.forced = 1'b1;
			n.pend = 1'b0;
			loss_evt = 1'b1;
		end

		// Standby UV before the rest is up latches everything off
		if (q.arm_sb && !q.arm_rest && sense_i.uv_sb33
			&& q.phase != PH_LATCHOFF) begin
			lock_evt = 1'b1;
		end

		// Enable is tracked only in the windows where change is legal
		if (q.phase inside {PH_FAST, PH_RAMP1, PH_DIS1, PH_WAIT3,
			PH_ACTRAMP, PH_ACTDIS, PH_ACTIVE}) begin
			n.en_lat = q.sy2[2];
		end

		if (!sense_i.bias_por_ok) begin
			n.phase = PH_OFF;
			n.arm_sb = 1'b0;
			n.arm_rest = 1'b0;
			n.lock = 1'b0;
			n.forced = 1'b0;
			n.pend = 1'b0;
			n.en_lat = q.sy2[2];
		end else if (lock_evt || q.lock) begin
			n.lock = 1'b1;
			n.phase = PH_LATCHOFF;
		end else if (shdn) begin
			n.phase = PH_SHDN;
			n.arm_sb = 1'b0;
			n.arm_rest = 1'b0;
			n.forced = 1'b0;
			n.pend = 1'b0;
			n.en_lat = q.sy2[2];
			n.m33 = !sense_i.memory_voltage_select_low;
			n.m25 = !sense_i.memory_voltage_select_high;
		end

		// ======================================================
		// Output drive, registered from the next state
		act = n.phase inside {PH_ACTRAMP, PH_ACTDIS, PH_ACTIVE};
		slp = (n.acpi != AC_S0)
			&& (n.phase inside {PH_RAMP2, PH_DIS2, PH_SLEEP, PH_MAINS});
		up = !(n.phase inside {PH_OFF, PH_SHDN, PH_LATCHOFF});
		n.drv.ss_fast_charge = n.phase == PH_FAST;
		n.drv.ss_charge = n.phase inside {PH_RAMP1, PH_RAMP2, PH_ACTRAMP};
		n.drv.ss_discharge = (n.phase inside {PH_DIS1, PH_DIS2, PH_ACTDIS,
			PH_OFF, PH_SHDN, PH_LATCHOFF})
			|| (n.phase == PH_SLEEP && sense_i.ss_ge_1v25);
		n.drv.sb33_ref_ramp = up && n.phase != PH_FAST
			&& (n.phase != PH_RAMP1 || sense_i.ss_ge_1v25);
		n.drv.dual5_output = act || (slp && n.en_lat);
		n.drv.dual5_standby_gate = slp && n.en_lat;
		n.drv.active_switch_gate = act;
		n.drv.clkchip_output = act;
		n.drv.mem33_output = slp && n.m33;
		n.drv.mem25_sleep = slp && n.m25;
		n.drv.mem25_active = act && n.m25;
		n.drv.uv_arm_sb33 = n.arm_sb;
		n.drv.uv_arm_rest = n.arm_rest;

		// Faults use the outputs as they stand this cycle
		f_sb = q.arm_sb & sense_i.uv_sb33;
		f_mem = q.arm_rest & ((sense_i.uv_mem33
			& (q.drv.mem33_output | q.drv.active_switch_gate))
			| (sense_i.uv_mem25
			& (q.drv.mem25_sleep | q.drv.mem25_active)));
		f_d5 = q.drv.dual5_output & sense_i.uv_dual5;
		f_clk = q.drv.clkchip_output & sense_i.uv_clk;
		n.drv.fault = n.lock || (up && (f_sb || f_mem || f_d5 || f_clk
			|| n.forced));

		// Sticky log: a new event beats a clear in the same cycle
		n.flog = (q.flog & ~clr)
			| {lock_evt, loss_evt, f_clk, f_d5, f_mem, f_sb};

		// ======================================================
		// AHB-Lite: zero wait state, always OKAY
		take = hsel_i & hready_i & htrans_i[1];
		n.ad_v = take;
		n.ad_w = hwrite_i;
		n.ad_a = haddr_i[7:0];
		n.rdata = '0;
		n.rdy = 1'b1;
		n.resp = HRESP_OKAY;
		if (take && !hwrite_i) begin
			if (reg_is(haddr_i[7:0], REG_CTRL)) begin
				n.rdata = {31'h0, q.shdn_sw};
			end else if (reg_is(haddr_i[7:0], REG_STATUS)) begin
				n.rdata = {17'h0, q.pend, q.arm_rest, q.arm_sb, q.lock,
					q.forced, q.m25, q.m33, q.en_lat, q.drv.fault,
					q.acpi, q.phase};
			end else if (reg_is(haddr_i[7:0], REG_FLOG)) begin
				n.rdata = {26'h0, q.flog};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.req <= REQ_RST;
			q.rdy <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign drive_o = q.drv;
	assign hrdata_o = q.rdata;
	assign hreadyout_o = q.rdy;
	assign hresp_o = q.resp;

endmodule

// ===== testbench/acpisq_monitor.sv
// Port checks of the sleep power sequencer
`timescale 1ns/1ps
module acpisq_monitor
	import acpisq_pkg::*;
#(
	parameter int unsigned ACT_ASSESS_CYC_P = 80
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Watched ports
	input wire logic suspend_request_n_i,
	input wire acpisq_sense_t sense_i,
	input wire acpisq_drive_t drive_o
);
	// ====
	// Run lengths of a low request and of good mains
	int low_q;
	int ok_q;
	always_ff @(posedge clk_i) begin
		low_q <= suspend_request_n_i ? 0 : low_q + 1;
		ok_q <= (sense_i.main33_ok & sense_i.main5_ok & sense_i.main12_ok)
			? ok_q + 1 : 0;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence gate_up;
		$rose(drive_o.active_switch_gate);
	endsequence
	sequence ramp_on;
		drive_o.clkchip_output && drive_o.ss_charge;
	endsequence
	// Shutdown still sinks the soft-start node
	localparam acpisq_drive_t DRV_DOWN = '{ss_discharge: 1'h1,
		default: 1'h0};
	clk_reg_a: assert property (
		drive_o.clkchip_output |-> drive_o.active_switch_gate)
		else $error("clock regulator on in sleep");
	sb_gate_a: assert property (
		drive_o.dual5_standby_gate |-> !drive_o.active_switch_gate)
		else $error("both dual supplies on");
	ext_off_a: assert property (
		sense_i.ss_ext_low |=> drive_o == DRV_DOWN)
		else $error("outputs alive in shutdown");
	// Mains loss also drops the gate, so falls with mains down do not count
	sleep_delay_a: assert property (
		$fell(drive_o.active_switch_gate) && ok_q > 0 &&
		!sense_i.ss_ext_low |-> low_q >= 4040)
		else $error("sleep entered too early");
	wake_wait_a: assert property (
		gate_up |-> ok_q >= int'(ACT_ASSESS_CYC_P))
		else $error("switches on before mains settle");
	gate_ramp_a: assert property (
		gate_up |-> ramp_on)
		else $error("gate without active ramp");
	por_fast_a: assert property (
		$rose(sense_i.bias_por_ok) |-> ##[1:2] drive_o.ss_fast_charge)
		else $error("no precharge after bias");
	fast_slow_a: assert property (
		drive_o.ss_fast_charge && sense_i.ss_ge_1v0 |-> ##[1:2]
		(drive_o.ss_charge && !drive_o.ss_fast_charge))
		else $error("precharge not handed over");
	dual5_uv_a: assert property (
		drive_o.dual5_output && sense_i.uv_dual5 && sense_i.bias_por_ok
		&& !sense_i.ss_ext_low |=> drive_o.fault)
		else $error("dual output undervoltage not reported");
endmodule
bind acpisq_top acpisq_monitor #(.ACT_ASSESS_CYC_P(ACT_ASSESS_CYC_P))
	mon_u (.clk_i(clk_i), .srst_i(srst_i),
	.suspend_request_n_i(suspend_request_n_i), .sense_i(sense_i),
	.drive_o(drive_o));

// ===== testbench/acpisq_partner.sv
// Supply monitors and soft-start node facing the sequencer
`timescale 1ns/1ps
module acpisq_partner
	import acpisq_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Bench controls
	input wire logic bias_i,
	input wire logic mains_i,
	input wire logic ext_low_i,
	input wire logic uv_i,
	// Sequencer link
	input wire acpisq_drive_t drive_i,
	output acpisq_sense_t sense_o
);
	// ====
	// Node in millivolts; standby output stays good once reached, until bias drops or the external pull-low is applied
	int v = 0;
	logic good = 1'h0;
	always_ff @(posedge clk_i) begin
		if (!bias_i || ext_low_i) v <= 0;
		else if (drive_i.ss_discharge) v <= (v > 50) ? v - 50 : 0;
		else if (drive_i.ss_fast_charge) v <= (v < 1000) ? v + 100 : v;
		else if (drive_i.ss_charge && v < 3300) v <= v + 25;
		good <= bias_i && !ext_low_i && (good || v >= 2500);
	end
	always_comb begin
		sense_o = '0; // Select pin open
		sense_o.bias_por_ok = bias_i;
		sense_o.ss_ext_low = ext_low_i;
		sense_o.ss_ge_1v0 = v >= 1000;
		sense_o.ss_ge_1v25 = v >= 1250;
		sense_o.ss_ge_2v45 = v >= 2450;
		sense_o.ss_ge_2v75 = v >= 2750;
		sense_o.sb33_in_reg = good;
		sense_o.uv_dual5 = uv_i;
		sense_o.uv_clk = uv_i;
		sense_o.main33_ok = mains_i;
		sense_o.main5_ok = mains_i;
		sense_o.main12_ok = mains_i;
	end
endmodule

// ===== testbench/acpisq_bench.sv
// Self-checking bench of the sleep power sequencer
`timescale 1ns/1ps
module acpisq_bench;
	import acpisq_pkg::*;
	typedef struct packed {
		logic s5n;
		logic en;
		logic [1:0] acpi;
	} acpisq_row_t;
	// ====
	// Stimulus and observed ports
	logic clk = 1'h0, rst = 1'h1, s3n = 1'h1, s5n = 1'h1, en = 1'h1;
	logic bias = 1'h0, mains = 1'h1, ext = 1'h0, hsel = 1'h0;
	logic hwrite = 1'h0, hrdy;
	logic uv = 1'h0;
	// Shutdown still sinks the soft-start node
	localparam acpisq_drive_t DRV_DOWN = '{ss_discharge: 1'h1,
		default: 1'h0};
	logic [1:0] htrans = 2'h0, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
	acpisq_sense_t sense;
	acpisq_drive_t drive;
	int error_cnt = 0, tests_run = 0, cyc = 0;
	acpisq_row_t rows [4] = '{'{1'h1, 1'h1, AC_S3}, '{1'h0, 1'h1, AC_S5},
		'{1'h1, 1'h0, AC_S3}, '{1'h0, 1'h0, AC_S5}};
	acpisq_row_t r;
	acpisq_top #(.CFG_WINDOW_CYC_P(50), .ACT_ASSESS_CYC_P(80)) dut_u (
		.clk_i(clk), .srst_i(rst), .suspend_request_n_i(s3n),
		.softoff_request_n_i(s5n), .dual5_sleep_enable_i(en),
		.sense_i(sense), .drive_o(drive), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp));
	acpisq_partner par_u (.clk_i(clk), .bias_i(bias), .mains_i(mains),
		.ext_low_i(ext), .uv_i(uv), .drive_i(drive), .sense_o(sense));
	initial forever #25 clk = ~clk;
	// ====
	// Tasks
	task automatic give_verdict();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hrdy !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'h1);
		st = hrdata;
	endtask
	task automatic wait_ph(input logic [3:0] p);
		do bus(1'h0, REG_STATUS, 32'h0); while (st[3:0] !== p);
	endtask
	function automatic logic [31:0] dg();
		return {28'h0, drive.active_switch_gate, drive.clkchip_output,
			drive.dual5_output, drive.dual5_standby_gate};
	endfunction
	// Whole run needs about 20k cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end
	// ====
	// Sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		chk(32'(drive), 32'h0);
		chk({29'h0, hrdy, hresp}, 32'h4);
		bias <= 1'h1;
		wait_ph(4'hb);
		chk(dg(), 32'he);
		foreach (rows[i]) begin
			r = rows[i];
			en <= r.en;
			s5n <= r.s5n;
			repeat (60) @(posedge clk);
			s3n <= 1'h0;
			repeat (3900) @(posedge clk);
			bus(1'h0, REG_STATUS, 32'h0);
			chk(32'(st[3:0]), 32'hb);
			wait_ph(4'h7);
			// Second pass: enable flipped and, in the S3 rows, S3 to S5 crossing tried
			repeat (2) begin
				bus(1'h0, REG_STATUS, 32'h0);
				chk(32'(st[7:4]), 32'({r.en, 1'h0, r.acpi}));
				chk(dg(), {30'h0, r.en, r.en});
				en <= ~r.en;
				s5n <= 1'h0;
				repeat (100) @(posedge clk);
			end
			s3n <= 1'h1;
			s5n <= 1'h1;
			wait_ph(4'hb);
		end
		s3n <= 1'h0;
		repeat (20) @(posedge clk);
		s3n <= 1'h1;
		repeat (60) @(posedge clk);
		bus(1'h0, REG_STATUS, 32'h0);
		chk(32'({st[14], st[3:0]}), 32'hb);
		mains <= 1'h0;
		repeat (10) @(posedge clk);
		bus(1'h0, REG_STATUS, 32'h0);
		chk(32'(st[6:4]), 32'h6);
		chk(32'(drive.fault), 32'h1);
		ext <= 1'h1;
		repeat (3) @(posedge clk);
		chk(32'(drive), 32'(DRV_DOWN));
		ext <= 1'h0;
		bus(1'h0, 8'h0c, 32'h0);
		chk(st, 32'h0);
		bus(1'h1, REG_CTRL, 32'h1);
		bus(1'h0, REG_CTRL, 32'h0);
		chk(st, 32'h1);
		chk(32'(drive), 32'(DRV_DOWN));
		bus(1'h1, REG_CTRL, 32'h0);
		bus(1'h0, REG_FLOG, 32'h0);
		chk(32'(st[4]), 32'h1);
		bus(1'h1, REG_FLOG, 32'h10);
		bus(1'h0, REG_FLOG, 32'h0);
		chk(32'(st[4]), 32'h0);
		// Restart into active waits while mains stay down
		wait_ph(4'h8);
		repeat (100) @(posedge clk);
		bus(1'h0, REG_STATUS, 32'h0);
		chk(32'({st[6], st[3:0]}), 32'h8);
		chk(dg(), 32'h0);
		mains <= 1'h1;
		wait_ph(4'hb);
		chk(dg(), 32'he);
		uv <= 1'h1;
		repeat (3) @(posedge clk);
		chk(32'(drive.fault), 32'h1);
		uv <= 1'h0;
		bus(1'h0, REG_FLOG, 32'h0);
		chk(32'(st[3:2]), 32'h3);
		chk(32'(drive.fault), 32'h0);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		chk(32'(drive), 32'h0);
		give_verdict();
	end
endmodule
